// >>> logic/sttd_decoder.v
// Notes on behaviour
// R1: sender gives any non-zero pre-roll of at least 4000 ms.
// R2: zero pre-roll only for immediate start or immediate end.
// R3: scheduled finish always carries a non-zero pre-roll.
// R4: immediate finish sets the immediate flag, aborting insertion.
// R5: time of day is 4-byte seconds then 2-byte microseconds, MSB first.
// R6: seconds count from midnight UTC 6 Jan 1980, leap seconds included.
// R7: kind 0 means no time; fire without waiting.
// R8: kind 1 reads 4-byte seconds, 2-byte microseconds; fire at that time.
// R9: kind 2 reads hours, minutes, seconds, frames; fire on timecode.
// R10: kind 3 reads input number and edge; fire on that contact edge.
// R11: undefined non-zero kind is ignored and reported as unsupported.
// R12: hours valid 0 to 23.
// R13: minutes and seconds valid 0 to 59.
// R14: frames valid 0-29 at 30 Hz, 0-24 at 25 Hz.
// R15: missing physical input: discard the request and raise an alarm.
// R16: edge 0 fires open to closed, edge 1 closed to open.
// R17: dropped target frame: fire on the first frame after it.
// R18: same event tag means the same insertion opportunity.
// R19: instance select picks which instance handles the message.
// R20: sender select tells multiplexed senders apart.
// R21: a pending message fires once, then leaves the pending set.
`timescale 1ns/10ps
`include "sttd_regs.vh"
module sttd_decoder (
   // clock and reset
   input  wire        clk_sys,
   input  wire        rst_b,
   input  wire        clk_en,
   // request byte stream, same clock domain
   input  wire        req_valid,
   input  wire [7:0]  req_byte,
   input  wire        req_last,
   // time references, same clock domain
   input  wire [31:0] abs_time_sec,
   input  wire [15:0] abs_time_usec,
   input  wire        tc_strobe,
   input  wire [31:0] tc_value,
   // contact closure pins, 1 = closed, asynchronous
   input  wire [7:0]  contact_pin,
   // register port
   input  wire [3:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [31:0] reg_rdata,
   // results
   output reg         fire,
   output reg  [31:0] fire_event_tag,
   output reg  [7:0]  fire_op,
   output reg         fire_immediate,
   output reg         req_error,
   output reg  [3:0]  req_error_code,
   output reg         operator_alarm
);
   // ==========================================================
   // parser states
   localparam ST_INST  = 3'd0;
   localparam ST_SEND  = 3'd1;
   localparam ST_OP    = 3'd2;
   localparam ST_TAG   = 3'd3;
   localparam ST_PRE   = 3'd4;
   localparam ST_KIND  = 3'd5;
   localparam ST_BODY  = 3'd6;
   localparam ST_DROP  = 3'd7;

   reg  [2:0]  state;
   reg  [2:0]  cnt;
   reg  [7:0]  instance_select;
   reg  [7:0]  sender_select;
   reg  [7:0]  op;
   reg  [31:0] insertion_event_tag;
   reg  [15:0] preroll;
   reg  [7:0]  kind;
   reg  [47:0] body;
   // control registers
   reg  [7:0]  ctrl;
   reg  [7:0]  my_instance;
   reg  [7:0]  inputs_present;
   reg  [7:0]  sender_mask;
   // pending slot
   reg         pend;
   reg  [31:0] pend_tag;
   reg  [7:0]  pend_op;
   reg  [7:0]  pend_sender;
   reg  [7:0]  pend_kind;
   reg  [47:0] pend_body;
   reg  [31:0] tc_prev;
   reg  [7:0]  contact_prev;
   reg  [3:0]  last_err;
   reg  [7:0]  err_count;
   wire [7:0]  contact_s;
   wire        tc_ok;
   wire        rate_25;
   wire [47:0] body_nx;

   assign rate_25 = ctrl[1];

   // pins cross into the clock domain first
   sttd_sync #(.W(8)) u_sync (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .clk_en  (clk_en),
      .din     (contact_pin),
      .dout    (contact_s)
   );

   // checks the timecode just parsed
   sttd_range u_range (
      .hours   (body_nx[31:24]),
      .minutes (body_nx[23:16]),
      .seconds (body_nx[15:8]),
      .frames  (body_nx[7:0]),
      .rate_25 (rate_25),
      .ok      (tc_ok)
   );

   // ====================
   // byte count of each timestamp body
   function [2:0] body_len;
      input [7:0] k;
      begin
         case (k)
            `STTD_KIND_ABS:     body_len = 3'd6; // [R8]
            `STTD_KIND_TC:      body_len = 3'd4; // [R9]
            `STTD_KIND_CONTACT: body_len = 3'd2; // [R10]
            default:            body_len = 3'd0;
         endcase
      end
   endfunction

   // ====================
   // completed-request decode
   wire        at_end  = req_valid & (state == ST_BODY) & (cnt == 3'd1);
   wire        kind_end = req_valid & (state == ST_KIND);
   wire        for_me  = (instance_select == my_instance);                // [R19]
   wire        sender_ok = sender_mask[sender_select[2:0]];               // [R20]
   wire [2:0]  k_len   = body_len(req_byte);
   wire        k_bad   = (req_byte > `STTD_KIND_CONTACT);                 // [R11]
   assign body_nx = {body[39:0], req_byte};
   wire        is_now  = (op == `STTD_OP_BEGIN_NOW) | (op == `STTD_OP_FINISH_NOW);
   // pre-roll sanity: zero only for immediate ops, else at least minimum
   wire        pre_bad = (preroll == 16'h0000) ? ~is_now                 // [R2] [R3]
                       : (preroll < `STTD_MIN_PREROLL_MS);               // [R1]
   // contact select lives in byte 1 of a two-byte body
   wire [7:0]  in_sel  = body[7:0];
   wire        in_miss = (in_sel > 8'h07) | ~inputs_present[in_sel[2:0]]; // [R15]

   // ====================
   // trigger match on the pending slot
   wire [7:0]  edge_sel = pend_body[7:0];
   wire [2:0]  pin_idx  = pend_body[10:8];
   wire        rise = contact_s[pin_idx] & ~contact_prev[pin_idx];
   wire        fall = ~contact_s[pin_idx] & contact_prev[pin_idx];
   // timecode: exact hit, or first frame after jumping past it
   wire        tc_hit = tc_strobe & ((tc_value == pend_body[31:0]) |        // [R9]
                        ((tc_prev < pend_body[31:0]) &                    // [R17]
                         (tc_value > pend_body[31:0])));
   // absolute time: 32-bit seconds and 16-bit microsecond offset, MSB first
   wire        abs_hit = ({abs_time_sec, abs_time_usec} >= pend_body);    // [R6] [R8]
   reg         match;

   always @* begin
      case (pend_kind)
         `STTD_KIND_ABS:     match = abs_hit;
         `STTD_KIND_TC:      match = tc_hit;
         `STTD_KIND_CONTACT: match = (edge_sel == `STTD_EDGE_CLOSE) ? rise // [R16]
                                   : fall;
         default:            match = 1'b1;
      endcase
   end

   // ==========================================================
   // byte parser; header is inst, sender, op, tag[4], preroll[2], kind
   always @(posedge clk_sys) begin
      if (!rst_b) begin
         state <= ST_INST;
         cnt <= 3'd0;
         instance_select <= 8'h00;
         sender_select <= 8'h00;
         op <= 8'h00;
         insertion_event_tag <= 32'h0;
         preroll <= 16'h0;
         kind <= 8'h00;
         body <= 48'h0;
      end else if (clk_en && req_valid) begin
         if (req_last) begin
            state <= ST_INST; // frame end always resynchronises
         end else begin
            case (state)
               ST_INST: begin
                  instance_select <= req_byte;
                  state           <= ST_SEND;
               end
               ST_SEND: begin
                  sender_select <= req_byte;
                  state         <= ST_OP;
               end
               ST_OP: begin
                  op    <= req_byte;
                  cnt   <= 3'd4;
                  state <= ST_TAG;
               end
               ST_TAG: begin
                  insertion_event_tag <= {insertion_event_tag[23:0], req_byte};
                  cnt                 <= cnt - 3'd1;
                  if (cnt == 3'd1) begin
                     cnt   <= 3'd2;
                     state <= ST_PRE;
                  end
               end
               ST_PRE: begin
                  preroll <= {preroll[7:0], req_byte};
                  cnt     <= cnt - 3'd1;
                  if (cnt == 3'd1)
                     state <= ST_KIND;
               end
               ST_KIND: begin
                  kind  <= req_byte;
                  cnt   <= k_len;
                  body  <= 48'h0;
                  state <= (k_len == 3'd0) ? ST_DROP : ST_BODY;
               end
               ST_BODY: begin
                  body <= body_nx;
                  cnt  <= cnt - 3'd1;
                  if (cnt == 3'd1)
                     state <= ST_DROP;
               end
               default: state <= ST_DROP; // trailing bytes until frame end
            endcase
         end
      end
   end

   // ==========================================================
   // acceptance, pending slot, firing and errors
   reg        accept;
   reg [3:0]  err;
   reg [7:0]  acc_kind;
   reg [47:0] acc_body;

   always @* begin
      accept   = 1'b0;
      err      = `STTD_ERR_NONE;
      acc_kind = kind;
      acc_body = body_nx;
      if (kind_end && (k_len == 3'd0)) begin
         acc_kind = req_byte;
         acc_body = 48'h0;
         if (k_bad)
            err = `STTD_ERR_KIND; // [R11]
         else if (pre_bad)
            err = `STTD_ERR_PREROLL;
         else
            accept = 1'b1; // [R7]
      end else if (at_end) begin
         if (pre_bad)
            err = `STTD_ERR_PREROLL;
         else if ((kind == `STTD_KIND_TC) && !tc_ok)
            err = `STTD_ERR_RANGE; // [R12] [R13] [R14]
         else if ((kind == `STTD_KIND_CONTACT) && in_miss)
            err = `STTD_ERR_NO_INPUT; // [R15]
         else
            accept = 1'b1;
      end
      if (!for_me || !sender_ok) begin
         accept = 1'b0; // [R19] [R20]
         err    = `STTD_ERR_NONE;
      end
   end

   always @(posedge clk_sys) begin
      if (!rst_b) begin
         pend <= 1'b0;
         pend_tag <= 32'h0;
         pend_op <= 8'h00;
         pend_sender <= 8'h00;
         pend_kind <= 8'h00;
         pend_body <= 48'h0;
         tc_prev <= 32'h0;
         contact_prev <= 8'h00;
         fire <= 1'b0;
         fire_event_tag <= 32'h0;
         fire_op <= 8'h00;
         fire_immediate <= 1'b0;
         req_error <= 1'b0;
         req_error_code <= `STTD_ERR_NONE;
         operator_alarm <= 1'b0;
         last_err <= `STTD_ERR_NONE;
         err_count <= 8'h00;
      end else if (clk_en) begin
         contact_prev <= contact_s;
         if (tc_strobe)
            tc_prev <= tc_value;
         fire      <= 1'b0;
         req_error <= 1'b0;
         if (err != `STTD_ERR_NONE) begin
            req_error <= 1'b1;
            req_error_code <= err;
            last_err <= err;
            err_count <= err_count + 8'h01;
         end
         // clear first, so a new alarm in the same cycle wins
         if (ctrl[0] || (reg_wr && reg_addr == `STTD_REG_STATUS))
            operator_alarm <= 1'b0;
         if (err == `STTD_ERR_NO_INPUT)
            operator_alarm <= 1'b1; // [R15]
         if (pend && match) begin
            fire <= 1'b1; // [R21]
            fire_event_tag <= pend_tag;
            fire_op <= pend_op;
            fire_immediate <= (pend_op == `STTD_OP_FINISH_NOW); // [R4]
            pend <= 1'b0; // [R21]
         end
         // a new request replaces the slot; same tag reuses the opportunity
         if (accept) begin
            pend <= 1'b1; // [R18]
            pend_tag <= insertion_event_tag;
            pend_op <= op;
            pend_sender <= sender_select;
            pend_kind <= acc_kind;
            pend_body <= acc_body;
         end
         // immediate finish aborts whatever is still waiting
         if (accept && (op == `STTD_OP_FINISH_NOW))
            pend_kind <= `STTD_KIND_NOW; // [R4]
      end
   end

   // ====================
   // register port; read data one cycle after the strobe
   always @(posedge clk_sys) begin
      if (!rst_b) begin
         ctrl <= `STTD_CTRL_RST;
         my_instance <= 8'h00;
         inputs_present <= `STTD_INPUTS_RST;
         sender_mask <= 8'hFF;
         reg_rdata <= 32'h0;
      end else if (clk_en) begin
         ctrl[0] <= 1'b0; // alarm clear is self-clearing
         if (reg_wr) begin
            case (reg_addr)
               `STTD_REG_CTRL:   ctrl <= reg_wdata[7:0];
               `STTD_REG_INST:   begin
                  my_instance <= reg_wdata[7:0];
                  sender_mask <= reg_wdata[15:8];
               end
               `STTD_REG_INPUTS: inputs_present <= reg_wdata[7:0];
               default: ;
            endcase
         end
         reg_rdata <= 32'h0;
         if (reg_rd) begin
            case (reg_addr)
               `STTD_REG_CTRL:    reg_rdata <= {24'h0, ctrl};
               `STTD_REG_INST:    reg_rdata <= {16'h0000, sender_mask, my_instance};
               `STTD_REG_INPUTS:  reg_rdata <= {16'h0000, contact_s, inputs_present};
               `STTD_REG_STATUS:  reg_rdata <= {pend_sender, err_count, 7'h00,
                                                operator_alarm, pend_kind[2:0],
                                                pend, last_err};
               `STTD_REG_EVENT:   reg_rdata <= pend_tag;
               `STTD_REG_ABS_NOW: reg_rdata <= abs_time_sec; // [R5]
               default:           reg_rdata <= 32'h00000000;
            endcase
         end
      end
   end
endmodule // sttd_decoder

// >>> logic/sttd_regs.vh
`ifndef STTD_REGS_VH
`define STTD_REGS_VH
// ==========================================================
// trigger kinds
`define STTD_KIND_NOW        8'h00
`define STTD_KIND_ABS        8'h01
`define STTD_KIND_TC         8'h02
`define STTD_KIND_CONTACT    8'h03
// ==========================================================
// operation codes of the request header
`define STTD_OP_BEGIN_NOW    8'h01
`define STTD_OP_FINISH_SCHED 8'h02
`define STTD_OP_FINISH_NOW   8'h03
// ==========================================================
// field limits
`define STTD_HOURS_MAX       8'h17
`define STTD_MINSEC_MAX      8'h3B
`define STTD_FRAMES_MAX_30   8'h1D
`define STTD_FRAMES_MAX_25   8'h18
`define STTD_MIN_PREROLL_MS  16'h0FA0
`define STTD_EDGE_CLOSE      8'h00
`define STTD_EDGE_OPEN       8'h01
// ==========================================================
// error codes
`define STTD_ERR_NONE        4'h0
`define STTD_ERR_KIND        4'h1
`define STTD_ERR_RANGE       4'h2
`define STTD_ERR_NO_INPUT    4'h3
`define STTD_ERR_PREROLL     4'h4
// ==========================================================
// register offsets and reset values
`define STTD_REG_CTRL        4'h0
`define STTD_REG_INST        4'h1
`define STTD_REG_INPUTS      4'h2
`define STTD_REG_STATUS      4'h3
`define STTD_REG_EVENT       4'h4
`define STTD_REG_ABS_NOW     4'h5
`define STTD_CTRL_RST        8'h00
`define STTD_INPUTS_RST      8'h08
`endif

// >>> logic/sttd_sync.v
`timescale 1ns/10ps
// ==========================================================
// two-stage synchroniser for a bundle of pins
module sttd_sync #(
   parameter W = 8
) (
   // clock
   input  wire         clk_sys,
   input  wire         rst_b,
   input  wire         clk_en,
   // data
   input  wire [W-1:0] din,
   output reg  [W-1:0] dout
);
   reg [W-1:0] meta;

   // first stage feeds only the second
   always @(posedge clk_sys) begin
      if (!rst_b) begin
         meta <= {W{1'b0}};
         dout <= {W{1'b0}};
      end else if (clk_en) begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule // sttd_sync

// >>> logic/sttd_range.v
`timescale 1ns/10ps
`include "sttd_regs.vh"
// ==========================================================
// timecode field range check, purely combinational
module sttd_range (
   // fields
   input  wire [7:0] hours,
   input  wire [7:0] minutes,
   input  wire [7:0] seconds,
   input  wire [7:0] frames,
   input  wire       rate_25,
   // result
   output wire       ok
);
   wire [7:0] fmax;

   assign fmax = rate_25 ? `STTD_FRAMES_MAX_25 : `STTD_FRAMES_MAX_30; // [R14]
   assign ok   = (hours <= `STTD_HOURS_MAX)                         // [R12]
               & (minutes <= `STTD_MINSEC_MAX)                      // [R13]
               & (seconds <= `STTD_MINSEC_MAX)                      // [R13]
               & (frames <= fmax);                                  // [R14]
endmodule // sttd_range

// >>> dv/sttd_checker.sv
`timescale 1ns/10ps
`include "sttd_regs.vh"
// ==========================================================
// port-level checks of the trigger decoder
module sttd_checker (
   // clock and reset
   input wire        clk_sys,
   input wire        rst_b,
   // register port
   input wire [3:0]  reg_addr,
   input wire [31:0] reg_wdata,
   input wire        reg_wr,
   // results
   input wire        fire,
   input wire [31:0] fire_event_tag,
   input wire [7:0]  fire_op,
   input wire        fire_immediate,
   input wire        req_error,
   input wire [3:0]  req_error_code,
   input wire        operator_alarm
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // status write clears at once, control bit0 write one cycle later
   wire clr_st = reg_wr && reg_addr == `STTD_REG_STATUS;
   wire clr_ct = reg_wr && reg_addr == `STTD_REG_CTRL && reg_wdata[0];
   // ==========================================================
   // assertions
   fire_once_a: assert property (fire |=> !fire)
      else $error("fire pulse longer than one cycle");
   err_pulse_a: assert property (req_error |=> !req_error)
      else $error("error pulse longer than one cycle");
   err_code_a: assert property (req_error |-> req_error_code inside
      {`STTD_ERR_KIND, `STTD_ERR_RANGE, `STTD_ERR_NO_INPUT, `STTD_ERR_PREROLL})
      else $error("error pulse with no valid code");
   no_input_alarm_a: assert property (req_error &&
      req_error_code == `STTD_ERR_NO_INPUT |-> ##[0:1] operator_alarm)
      else $error("missing input raised no alarm");
   alarm_cause_a: assert property ($rose(operator_alarm) |->
      (req_error || $past(req_error)) && req_error_code == `STTD_ERR_NO_INPUT)
      else $error("alarm raised without missing input");
   alarm_hold_a: assert property (operator_alarm && !clr_st && !$past(clr_ct)
      |=> operator_alarm)
      else $error("alarm dropped without a clear");
   imm_op_a: assert property (fire |->
      fire_immediate == (fire_op == `STTD_OP_FINISH_NOW))
      else $error("immediate flag does not match operation");
   fire_hold_a: assert property (!fire |->
      $stable(fire_event_tag) && $stable(fire_op))
      else $error("fire data changed without a fire");
   // main scenarios reached
   cover property (fire && fire_immediate);
   cover property (req_error && req_error_code == `STTD_ERR_RANGE);
   cover property (operator_alarm ##1 !operator_alarm);
endmodule // sttd_checker

bind sttd_decoder sttd_checker u_chk (
   .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .fire(fire), .fire_event_tag(fire_event_tag),
   .fire_op(fire_op), .fire_immediate(fire_immediate), .req_error(req_error),
   .req_error_code(req_error_code), .operator_alarm(operator_alarm));

// >>> dv/sttd_sender.sv
`timescale 1ns/10ps
`include "sttd_regs.vh"
// ==========================================================
// automation sender: frames of request bytes
module sttd_sender (
   // clock
   input  wire        clk_sys,
   // byte stream
   output logic       req_valid,
   output logic [7:0] req_byte,
   output logic       req_last
);
   // idle line shows the inverse of the dummy byte
   initial begin
      req_valid = 1'b0;
      req_byte  = 8'hA5;
      req_last  = 1'b0;
   end
   // header, body, then an unparsed closing byte
   task automatic send(input logic [7:0] inst, snd, op, kind,
                       input logic [31:0] tag, input logic [47:0] body,
                       input int nb, input bit bad_pre);
      logic [15:0]  pre;
      logic [127:0] all;
      pre = `STTD_MIN_PREROLL_MS;
      if (op == `STTD_OP_BEGIN_NOW || op == `STTD_OP_FINISH_NOW)
         pre = 16'h0000;
      if (bad_pre)
         pre = 16'h0F9F;                              // short on purpose
      all = {inst, snd, op, tag, pre, kind, body};
      for (int i = 0; i <= 10 + nb; i++) begin
         @(posedge clk_sys);
         req_valid <= 1'b1;
         req_byte  <= (i == 10 + nb) ? 8'h5A : all[127-8*i -: 8];
         req_last  <= (i == 10 + nb);
      end
      @(posedge clk_sys);
      req_valid <= 1'b0;
      req_last  <= 1'b0;
      req_byte  <= 8'hA5;
   endtask
endmodule // sttd_sender

// >>> dv/sttd_decoder_bench.sv
`timescale 1ns/10ps
`include "sttd_regs.vh"
// ==========================================================
// self-checking bench of the trigger decoder
module sttd_decoder_bench;
   logic        clk_sys = 1'b0;
   logic        rst_b = 1'b0;
   logic        req_valid, req_last;
   logic [7:0]  req_byte;
   logic [31:0] abs_time_sec = 32'h0, tc_value = 32'h0, reg_wdata = 32'h0;
   logic [15:0] abs_time_usec = 16'h0;
   logic        tc_strobe = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0]  contact_pin = 8'h00;
   logic [3:0]  reg_addr = 4'h0;
   wire  [31:0] reg_rdata, fire_event_tag;
   wire  [7:0]  fire_op;
   wire  [3:0]  req_error_code;
   wire         fire, fire_immediate, req_error, operator_alarm;
   int          error_cnt = 0;
   int          n_tests = 0;
   int          nf = 0, ne = 0, cyc = 0;
   logic [31:0] seed = 32'h6BE4;
   logic [31:0] r;
   logic [7:0]  ukind [2] = '{8'h04, 8'hFF};
   logic [7:0]  noin [2] = '{8'h04, 8'hC8};
   logic [31:0] tcbad [5] = '{32'h18000000, 32'h003C0000, 32'h00003C00,
                              32'h0000001E, 32'h00000019};

   sttd_decoder u_sttd_decoder (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(1'b1),
      .req_valid(req_valid), .req_byte(req_byte), .req_last(req_last),
      .abs_time_sec(abs_time_sec), .abs_time_usec(abs_time_usec),
      .tc_strobe(tc_strobe), .tc_value(tc_value), .contact_pin(contact_pin),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .fire(fire), .fire_event_tag(fire_event_tag),
      .fire_op(fire_op), .fire_immediate(fire_immediate), .req_error(req_error),
      .req_error_code(req_error_code), .operator_alarm(operator_alarm));
   sttd_sender u_sttd_sender (.clk_sys(clk_sys), .req_valid(req_valid),
      .req_byte(req_byte), .req_last(req_last));

   initial forever #20 clk_sys = ~clk_sys;
   // count result pulses; a hang ends the run
   always @(posedge clk_sys) begin
      cyc++;
      if (fire === 1'b1) nf++;
      if (req_error === 1'b1) ne++;
      if (cyc == 5000) begin
         error_cnt++;
         conclude();
      end
   end
   // ==========================================================
   // helpers
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function int exp_fire(input logic [7:0] i, s);
      return (i == 8'h05 && s != 8'h02);
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      #1;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   // one frame, then time for results to land
   task automatic xfer(input logic [7:0] i, s, op, k, input logic [31:0] t,
                       input logic [47:0] b, input int nb, input bit bad,
                       output int df, output int de);
      int f0, e0;
      f0 = nf;
      e0 = ne;
      u_sttd_sender.send(i, s, op, k, t, b, nb, bad);
      repeat (8) @(posedge clk_sys);
      #1;
      df = nf - f0;
      de = ne - e0;
   endtask
   // own instance, enabled sender, immediate start
   task automatic go(input logic [7:0] k, input logic [47:0] b, input int nb,
                     output int df, de);
      xfer(8'h05, 8'h01, `STTD_OP_BEGIN_NOW, k, r, b, nb, 1'b0, df, de);
   endtask
   task automatic tc(input logic [31:0] v);
      @(posedge clk_sys);
      tc_strobe <= 1'b1;
      tc_value <= v;
      @(posedge clk_sys);
      tc_strobe <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
   endtask
   // pins pass a two-flop synchroniser first
   task automatic pin(input logic [7:0] v);
      @(posedge clk_sys);
      contact_pin <= v;
      repeat (6) @(posedge clk_sys);
      #1;
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ==========================================================
   // main sequence
   initial begin
      int df, de;
      logic [7:0] ins, sn;
      repeat (12) @(posedge clk_sys);
      rst_b <= 1'b1;
      rd(`STTD_REG_CTRL, {24'h0, `STTD_CTRL_RST});
      rd(`STTD_REG_INPUTS, {24'h0, `STTD_INPUTS_RST});
      rd(4'hF, 32'h0);
      wr(`STTD_REG_INST, 32'h0000FB05);
      rd(`STTD_REG_INST, 32'h0000FB05);
      // each op with no time; scheduled finish at minimum pre-roll
      for (int op = 1; op <= 3; op++) begin
         r = rnd();
         xfer(8'h05, 8'h01, op[7:0], `STTD_KIND_NOW, r, 48'h0, 0, 1'b0, df, de);
         chk(df, 1);
         chk(fire_event_tag, r);
         chk(fire_op, op);
         chk(fire_immediate, op == 3);
      end
      xfer(8'h05, 8'h01, `STTD_OP_FINISH_SCHED, `STTD_KIND_NOW, r, 48'h0, 0, 1'b1, df, de);
      chk(de, 1);
      chk(req_error_code + df, `STTD_ERR_PREROLL);
      // routing by instance and sender, a disabled sender first
      xfer(8'h05, 8'h02, `STTD_OP_BEGIN_NOW, `STTD_KIND_NOW, r, 48'h0, 0, 1'b0, df, de);
      chk(df, 0);
      repeat (8) begin
         r = rnd();
         ins = r[8] ? 8'h05 : r[7:0];
         sn = {5'h0, r[18:16]};
         xfer(ins, sn, `STTD_OP_BEGIN_NOW, `STTD_KIND_NOW, r, 48'h0, 0, 1'b0, df, de);
         chk(df, exp_fire(ins, sn));
      end
      foreach (ukind[i]) begin
         go(ukind[i], 48'h0, 0, df, de);
         chk({df[3:0], de[3:0], req_error_code}, {8'h01, `STTD_ERR_KIND});
      end
      // absolute time: nothing early, fire once the time arrives
      @(posedge clk_sys);
      abs_time_sec <= 32'h12345677;
      abs_time_usec <= r[15:0];
      r = rnd();
      xfer(8'h05, 8'h01, `STTD_OP_FINISH_SCHED, `STTD_KIND_ABS, r,
           48'h123456780000, 6, 1'b0, df, de);
      chk(df + de, 0);
      rd(`STTD_REG_EVENT, r);
      rd(`STTD_REG_ABS_NOW, 32'h12345677);
      @(posedge clk_sys);
      abs_time_sec <= 32'h12345678;
      abs_time_usec <= 16'h0001;
      df = nf;
      repeat (4) @(posedge clk_sys);
      #1 chk(nf - df, 1);
      // timecode fields out of range, the last one at 25 Hz
      foreach (tcbad[i]) begin
         if (i == 4) wr(`STTD_REG_CTRL, 32'h2);
         go(`STTD_KIND_TC, {tcbad[i], 16'h0}, 4, df, de);
         chk({de[3:0], req_error_code}, {4'h1, `STTD_ERR_RANGE});
      end
      go(`STTD_KIND_TC, 48'h173B3B180000, 4, df, de);
      chk(de, 0);
      wr(`STTD_REG_CTRL, 32'h0);
      // timecode: dropped target frame, then no second fire
      go(`STTD_KIND_TC, 48'h010203040000, 4, df, de);
      df = nf;
      tc(32'h01020302);
      tc(32'h01020303);
      chk(nf - df, 0);
      tc(32'h01020305);
      chk(nf - df, 1);
      tc(32'h01020304);
      chk(nf - df, 1);
      go(`STTD_KIND_TC, 48'h010203060000, 4, df, de);
      df = nf;
      tc(32'h01020306);
      chk(nf - df, 1);
      // contact edges on the present input
      for (int e = 0; e < 2; e++) begin
         go(`STTD_KIND_CONTACT, {8'h03, e[7:0], 32'h0}, 2, df, de);
         df = nf;
         pin(8'h08);
         rd(`STTD_REG_INPUTS, 32'h00000808);
         chk(nf - df, 1 - e);
         pin(8'h00);
         chk(nf - df, 1);
      end
      // missing inputs: discarded, alarm until cleared
      foreach (noin[i]) begin
         go(`STTD_KIND_CONTACT, {noin[i], 40'h0}, 2, df, de);
         chk({de[3:0], req_error_code}, {4'h1, `STTD_ERR_NO_INPUT});
         chk(operator_alarm, 1);
         wr(`STTD_REG_STATUS, 32'h0);
         chk(operator_alarm, 0);
      end
      conclude();
   end
endmodule // sttd_decoder_bench
